// File: verilog/crpg_resp_gen.sv
// Response primitive generator with AXI4-Lite register access
// Function
// [RL1] Variant one: come-again set except null
// [RL2] Variant two may clear come-again on evaluate
// [RL3] Null word has fixed layout
// [RL4] Host honours interrupt-allow flag
// [RL5] Finished flag zero busy, one idle
// [RL6] Condition result meaningful only for conditionals
// [RL7] Predicate answer: all zero plus result
// [RL8] Idle answer: only finished flag set
// [RL9] Phase entry: only interrupt-allow set
// [RL10] Release with pass-counter only first response
// [RL11] Busy: come-again and interrupt-allow set
// [RL12] Busy with pass-counter only first response
// [RL13] Emit only the seven defined null codes
// [RL14] Host trace waits for finished flag
// [RL15] Host evaluates address, moves operand bytes
// [RL16] Host re-reads after come-again service
// [RL17] Come-again flag sits at bit 15
// [RL18] Pass-counter bit 14, once per dialog
// [RL19] Variant two flags missing counter transfer
// [RL20] Evaluate primitive replaced by null once read
// [RL21] Response register always shows pending primitive
`timescale 1ns/10ps
module crpg_resp_gen (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic [15:0] response_word,
  output wire logic        protocol_violation
);

  // ----------------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------------
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire rd_go = s_axi_arvalid && !rvalid_q;
  wire wr_ctrl  = wr_go && awaddr_q == crpg_pkg::CTRL_OFS;
  wire wr_event = wr_go && awaddr_q == crpg_pkg::EVENT_OFS;
  wire wr_eval  = wr_go && awaddr_q == crpg_pkg::EVAL_OFS;
  wire wr_ok    = wr_ctrl || wr_event || wr_eval;
  wire rd_resp  = rd_go && s_axi_araddr == crpg_pkg::RESP_OFS;
  wire rd_ok    = rd_go && (s_axi_araddr inside {crpg_pkg::CTRL_OFS,
                  crpg_pkg::EVENT_OFS, crpg_pkg::EVAL_OFS, crpg_pkg::RESP_OFS,
                  crpg_pkg::STATUS_OFS});

  // Event pulses only fire when byte lane 0 is enabled
  wire [6:0] ev = (wr_event && wstrb_q[0]) ? wdata_q[6:0] : 7'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= crpg_pkg::AXI_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? crpg_pkg::AXI_OKAY : crpg_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control and evaluate-primitive registers
  // ----------------------------------------------------------------------
  logic [3:0]  ctrl_q;
  logic [15:0] eval_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= crpg_pkg::CTRL_RST;
      eval_q <= 16'h0000;
    end else begin
      if (wr_ctrl && wstrb_q[0]) begin
        ctrl_q <= wdata_q[3:0];
      end
      if (wr_eval && wstrb_q[0]) begin
        eval_q[7:0] <= wdata_q[7:0];
      end
      if (wr_eval && wstrb_q[1]) begin
        eval_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  wire variant_two = ctrl_q[crpg_pkg::CTRL_VARIANT_BIT];
  wire cond_result = ctrl_q[crpg_pkg::CTRL_CRES_BIT];
  wire exc_enabled = ctrl_q[crpg_pkg::CTRL_EXC_BIT];
  wire ca_skip_ok  = ctrl_q[crpg_pkg::CTRL_CA_BIT];

  // ----------------------------------------------------------------------
  // Dialog state machine
  // ----------------------------------------------------------------------
  crpg_pkg::crpg_state_t state_q;
  crpg_pkg::crpg_state_t state_d;
  logic first_q;
  logic pc_req_q;
  logic cres_q;
  logic viol_q;
  logic [15:0] resp_word;

  always_comb begin
    state_d = state_q;
    case (state_q)
      crpg_pkg::CRPG_IDLE,
      crpg_pkg::CRPG_COND,
      crpg_pkg::CRPG_CONC,
      crpg_pkg::CRPG_BUSY: begin
        if (ev[crpg_pkg::EV_COND_BIT]) begin
          state_d = crpg_pkg::CRPG_COND;
        end else if (ev[crpg_pkg::EV_EVAL_BIT]) begin
          state_d = crpg_pkg::CRPG_EVAL;
        end else if (ev[crpg_pkg::EV_SERVICE_BIT]
                     || ev[crpg_pkg::EV_START_BIT]) begin
          state_d = crpg_pkg::CRPG_BUSY; // [RL11]
        end else if (ev[crpg_pkg::EV_CONC_BIT]) begin
          state_d = crpg_pkg::CRPG_CONC;
        end else if (ev[crpg_pkg::EV_DONE_BIT]) begin
          state_d = crpg_pkg::CRPG_IDLE;
        end
      end
      crpg_pkg::CRPG_EVAL: begin
        if (rd_resp) begin
          state_d = crpg_pkg::CRPG_BUSY; // [RL20]
        end
      end
      default: state_d = crpg_pkg::CRPG_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= crpg_pkg::CRPG_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // First response of a dialog: pass-counter may ride on it only once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_q  <= 1'b0;
      pc_req_q <= 1'b0;
      cres_q   <= 1'b0;
    end else begin
      if (ev[crpg_pkg::EV_START_BIT]) begin
        first_q <= 1'b1;
      end else if (rd_resp) begin
        first_q <= 1'b0; // [RL10] [RL12] [RL18]
      end
      if (rd_resp && resp_word[crpg_pkg::PC_BIT]) begin
        pc_req_q <= 1'b1;
      end else if (ev[crpg_pkg::EV_PCOK_BIT] || ev[crpg_pkg::EV_START_BIT]) begin
        pc_req_q <= 1'b0;
      end
      if (ev[crpg_pkg::EV_COND_BIT]) begin
        cres_q <= cond_result; // [RL6] [RL7]
      end
    end
  end

  // An open counter request at the next start: violation in variant two
  wire viol_set = variant_two && pc_req_q && ev[crpg_pkg::EV_START_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      viol_q <= 1'b0;
    end else if (viol_set) begin
      viol_q <= 1'b1; // [RL19]
    end else if (wr_ctrl && wstrb_q[0]) begin
      viol_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Response word selection
  // ----------------------------------------------------------------------
  wire pc_now = first_q && exc_enabled;
  crpg_pkg::crpg_null_t nflags;
  always_comb begin
    nflags = '0;
    case (state_q)
      crpg_pkg::CRPG_IDLE: nflags.processing_finished_flag = 1'b1; // [RL5] [RL8]
      crpg_pkg::CRPG_COND: nflags.condition_result_flag = cres_q; // [RL7]
      crpg_pkg::CRPG_CONC: begin
        nflags.interrupt_allow_flag = 1'b1; // [RL9]
        nflags.pass_counter_flag    = pc_now; // [RL10]
      end
      crpg_pkg::CRPG_BUSY: begin
        nflags.come_again_flag      = 1'b1; // [RL11]
        nflags.interrupt_allow_flag = 1'b1;
        nflags.pass_counter_flag    = pc_now; // [RL12]
      end
      default: nflags = '0;
    endcase
  end
  logic [15:0] null_word;
  crpg_null_enc u_null (
    .flags (nflags),
    .word  (null_word)
  );

  // Variant one always forces come-again on the evaluate primitive
  wire eval_ca = variant_two ? (eval_q[crpg_pkg::CA_BIT] || !ca_skip_ok)
                             : 1'b1; // [RL1] [RL2]
  wire eval_pc = eval_q[crpg_pkg::PC_BIT] && first_q;
  wire [15:0] eval_word = {eval_ca, eval_pc, eval_q[13:0]};
  assign resp_word = (state_q == crpg_pkg::CRPG_EVAL)
                     ? eval_word : null_word; // [RL13] [RL21]
  assign response_word      = resp_word;
  assign protocol_violation = viol_q;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      crpg_pkg::CTRL_OFS:   rd_mux = {28'h0000000, ctrl_q};
      crpg_pkg::EVAL_OFS:   rd_mux = {16'h0000, eval_q};
      crpg_pkg::RESP_OFS:   rd_mux = {16'h0000, resp_word};
      crpg_pkg::STATUS_OFS: rd_mux = {28'h0000000, viol_q, pc_req_q,
                                      first_q, state_q == crpg_pkg::CRPG_IDLE};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= crpg_pkg::AXI_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? crpg_pkg::AXI_OKAY : crpg_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_null_fixed;
    @(posedge aclk) disable iff (!aresetn)
    state_q != crpg_pkg::CRPG_EVAL |->
      resp_word[13:9] == 5'h04 && resp_word[7:2] == 6'h00;
  endproperty
  a_null_fixed: assert property (p_null_fixed) // [RL3]
    else $error("null fixed bits wrong");
  property p_idle;
    @(posedge aclk) disable iff (!aresetn)
    state_q == crpg_pkg::CRPG_IDLE |-> resp_word == 16'h0802;
  endproperty
  a_idle: assert property (p_idle) // [RL8]
    else $error("idle primitive wrong");
  property p_pf;
    @(posedge aclk) disable iff (!aresetn)
    state_q != crpg_pkg::CRPG_EVAL |->
      resp_word[1] == (state_q == crpg_pkg::CRPG_IDLE);
  endproperty
  a_pf: assert property (p_pf) // [RL5]
    else $error("finished flag wrong");
  property p_cond;
    @(posedge aclk) disable iff (!aresetn)
    ev[crpg_pkg::EV_COND_BIT] |=>
      resp_word == {15'h0400, $past(cond_result)};
  endproperty
  a_cond: assert property (p_cond) // [RL7]
    else $error("condition answer wrong");
  property p_conc;
    @(posedge aclk) disable iff (!aresetn)
    state_q == crpg_pkg::CRPG_CONC |-> resp_word[15] == 1'b0
      && resp_word[8] && !resp_word[1] && !resp_word[0];
  endproperty
  a_conc: assert property (p_conc) // [RL9]
    else $error("release primitive wrong");
  property p_busy;
    @(posedge aclk) disable iff (!aresetn)
    state_q == crpg_pkg::CRPG_BUSY |-> resp_word[15] && resp_word[8]
      && resp_word[1:0] == 2'h0;
  endproperty
  a_busy: assert property (p_busy) // [RL11]
    else $error("busy primitive wrong");
  property p_pc_first;
    @(posedge aclk) disable iff (!aresetn) resp_word[14] |-> first_q;
  endproperty
  a_pc_first: assert property (p_pc_first) // [RL12]
    else $error("pass counter outside first response");
  property p_v1_ca;
    @(posedge aclk) disable iff (!aresetn)
    state_q == crpg_pkg::CRPG_EVAL && !variant_two |-> resp_word[15];
  endproperty
  a_v1_ca: assert property (p_v1_ca) // [RL1]
    else $error("variant one evaluate without come-again");
  property p_eval_once;
    @(posedge aclk) disable iff (!aresetn)
    state_q == crpg_pkg::CRPG_EVAL && rd_resp |=>
      state_q == crpg_pkg::CRPG_BUSY;
  endproperty
  a_eval_once: assert property (p_eval_once) // [RL20]
    else $error("evaluate primitive not discarded");
  property p_viol;
    @(posedge aclk) disable iff (!aresetn) viol_set |=> viol_q;
  endproperty
  a_viol: assert property (p_viol) // [RL19]
    else $error("violation not flagged");

endmodule

// File: pkg/crpg_pkg.sv
// Package: constants and types for the coprocessor response primitive block
package crpg_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] EVENT_OFS  = 8'h04;
  localparam logic [7:0] EVAL_OFS   = 8'h08;
  localparam logic [7:0] RESP_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_CRES_BIT    = 1;
  localparam int CTRL_EXC_BIT     = 2;
  localparam int CTRL_CA_BIT      = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ----------------------------------------------------------------------
  // Event register bits (write one to fire)
  // ----------------------------------------------------------------------
  localparam int EV_START_BIT   = 0;
  localparam int EV_COND_BIT    = 1;
  localparam int EV_CONC_BIT    = 2;
  localparam int EV_SERVICE_BIT = 3;
  localparam int EV_DONE_BIT    = 4;
  localparam int EV_EVAL_BIT    = 5;
  localparam int EV_PCOK_BIT    = 6;

  // ----------------------------------------------------------------------
  // Primitive word layout
  // ----------------------------------------------------------------------
  localparam int CA_BIT = 15;
  localparam int PC_BIT = 14;
  localparam int IA_BIT = 8;
  localparam int PF_BIT = 1;
  localparam int TF_BIT = 0;
  localparam logic [4:0] NULL_FIXED = 5'h04;
  localparam logic [15:0] RESP_RST  = 16'h0802;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CRPG_IDLE, CRPG_COND, CRPG_CONC, CRPG_BUSY, CRPG_EVAL
  } crpg_state_t;

  typedef struct packed {
    logic come_again_flag;
    logic pass_counter_flag;
    logic interrupt_allow_flag;
    logic processing_finished_flag;
    logic condition_result_flag;
  } crpg_null_t;

endpackage

// File: verilog/crpg_null_enc.sv
// Null primitive word encoder
`timescale 1ns/10ps
module crpg_null_enc (
  input  wire crpg_pkg::crpg_null_t flags,
  output wire logic [15:0]          word
);
  // ----------------------------------------------------------------------
  // Encoding
  // ----------------------------------------------------------------------
  assign word = {flags.come_again_flag, flags.pass_counter_flag,
                 crpg_pkg::NULL_FIXED, flags.interrupt_allow_flag,
                 6'h00, flags.processing_finished_flag,
                 flags.condition_result_flag}; // [RL3] [RL17] [RL18]
endmodule

// File: bench/crpg_host_model.sv
// Host processor model: bus master that drives the response generator
`timescale 1ns/10ps
module crpg_host_model (
  input  logic        aclk,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end

  // ----------------------------------------------------------------------
  // Bus cycles; released payload is inverted so stale data never matches
  // ----------------------------------------------------------------------
  // Operand and predicate transfers all pass through here
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // No interrupts are modelled; a clear interrupt-allow is obeyed
  // Response register re-reads after come-again use this path
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// File: bench/tb_crpg_resp_gen.sv
// Self-checking bench for the response primitive generator
`timescale 1ns/10ps
module tb_crpg_resp_gen;
  localparam logic [7:0] A_CTRL = crpg_pkg::CTRL_OFS;
  localparam logic [7:0] A_EV   = crpg_pkg::EVENT_OFS;
  localparam logic [7:0] A_EVAL = crpg_pkg::EVAL_OFS;
  localparam logic [7:0] A_RESP = crpg_pkg::RESP_OFS;
  localparam logic [1:0] ERR    = crpg_pkg::AXI_SLVERR;
  localparam logic [15:0] IDLE  = 16'h0802;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [15:0] response_word;
  logic        protocol_violation;
  int          mismatches = 0;
  int          checks_done = 0;
  int          seed = 57;
  logic [31:0] rdat;
  logic [1:0]  resp;
  logic [15:0] ev_w;
  logic [15:0] ev_x;
  logic        cres;

  crpg_resp_gen u_crpg_resp_gen (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .response_word, .protocol_violation
  );

  crpg_host_model u_crpg_host_model (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] nullw(input logic ca, pc, ia, pf, tf);
    return {ca, pc, 5'h04, ia, 6'h00, pf, tf};
  endfunction

  // Only seven of the null codes may ever appear
  function automatic logic legal(input logic [15:0] x);
    logic [4:0] f;
    f = {x[15:14], x[8], x[1:0]};
    if (x[13:9] != 5'h04) return 1'b1;
    return (x[7:2] == 6'h00) &&
           (f inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h0c, 5'h14, 5'h1c});
  endfunction

  task automatic see(input string nm, input logic [15:0] exp);
    @(negedge aclk);
    chk(nm, {16'h0, response_word}, {16'h0, exp});
    chk("null code", {31'h0, legal(response_word)}, 32'h1);
  endtask

  task automatic pv(input logic e);
    @(negedge aclk);
    chk("violation", {31'h0, protocol_violation}, {31'h0, e});
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    u_crpg_host_model.wr(a, d, (a == A_EVAL) ? 4'h3 : 4'h1, resp);
  endtask

  task automatic r(input logic [7:0] a);
    u_crpg_host_model.rd(a, rdat, resp);
  endtask

  task automatic ev(input int b);
    w(A_EV, 32'h1 << b);
    chk("event resp", {30'h0, resp}, {30'h0, crpg_pkg::AXI_OKAY});
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Some sixty-four bus cycles of a few clocks each; ample margin
  initial begin
    repeat (6000) @(posedge aclk);
    mismatches++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    see("idle after reset", IDLE);
    pv(1'b0);
    r(A_RESP);
    chk("resp read", rdat, {16'h0, IDLE});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cres = (i < 2) ? i[0] : 1'($random(seed));
      w(A_CTRL, {30'h0, cres, 1'b0});
      ev(crpg_pkg::EV_COND_BIT);
      see("cond answer", nullw(1'b0, 1'b0, 1'b0, 1'b0, cres));
    end
    ev(crpg_pkg::EV_DONE_BIT);
    see("idle", IDLE);
    $display("test predicate done");
    w(A_CTRL, 32'h0);
    ev(crpg_pkg::EV_START_BIT);
    see("busy", nullw(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    ev(crpg_pkg::EV_CONC_BIT);
    see("release", nullw(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    ev(crpg_pkg::EV_DONE_BIT);
    see("idle", IDLE);
    w(A_CTRL, 32'h4);
    ev(crpg_pkg::EV_START_BIT);
    see("busy first", nullw(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    r(A_RESP);
    chk("busy read", rdat, 32'h0000c900);
    ev(crpg_pkg::EV_SERVICE_BIT);
    see("busy again", nullw(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    ev(crpg_pkg::EV_PCOK_BIT);
    ev(crpg_pkg::EV_DONE_BIT);
    ev(crpg_pkg::EV_START_BIT);
    ev(crpg_pkg::EV_CONC_BIT);
    see("release first", nullw(1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
    ev(crpg_pkg::EV_DONE_BIT);
    $display("test dialog done");
    for (int i = 0; i < 4; i++) begin
      ev_w = {2'b00, 1'($random(seed)), 2'b10, 3'($random(seed)),
              8'($random(seed))};
      ev_x = i[1] ? ev_w : (ev_w | 16'h8000);
      w(A_CTRL, i[1] ? 32'h9 : 32'h0);
      ev(crpg_pkg::EV_START_BIT);
      w(A_EVAL, {16'h0, ev_w});
      ev(crpg_pkg::EV_EVAL_BIT);
      see("eval word", ev_x);
      r(A_RESP);
      chk("eval read", rdat, {16'h0, ev_x});
      see("after eval", nullw(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
      ev(crpg_pkg::EV_DONE_BIT);
    end
    $display("test evaluate done");
    // Second variant flags a skipped counter transfer, first tolerates it
    for (int v = 0; v < 2; v++) begin
      w(A_CTRL, 32'h4 | v);
      ev(crpg_pkg::EV_START_BIT);
      r(A_RESP);
      r(crpg_pkg::STATUS_OFS);
      chk("status pending", rdat, 32'h4);
      ev(crpg_pkg::EV_START_BIT);
      pv(v[0]);
      w(A_CTRL, 32'h4 | v);
      pv(1'b0);
      ev(crpg_pkg::EV_DONE_BIT);
    end
    $display("test violation done");
    w(8'h20, 32'h1);
    chk("unmapped write", {30'h0, resp}, {30'h0, ERR});
    r(8'h20);
    chk("unmapped read", {30'h0, resp}, {30'h0, ERR});
    chk("unmapped data", rdat, 32'h0);
    w(A_RESP, 32'h0);
    chk("resp write", {30'h0, resp}, {30'h0, ERR});
    see("idle kept", IDLE);
    $display("test bus errors done");
    conclude();
  end
endmodule
